// File: pkg/caf_pkg.sv
// Constants for the CAN acceptance filter configuration block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word each.
package caf_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_MAIN_CTRL = 8'h00;
	localparam logic [7:0] OFS_FLT_GRP3 = 8'h04;
	localparam logic [7:0] OFS_BUF_BASE = 8'h08;
	localparam logic [7:0] OFS_MASK0 = 8'h10;
	localparam logic [7:0] OFS_FILT_ID0 = 8'h20;
	localparam logic [7:0] OFS_DEPTH0 = 8'h60;
	localparam logic [7:0] OFS_START0 = 8'hA0;
	localparam int WORD_SHIFT = 2;
	// Counts
	localparam int NUM_FILT = 16;
	localparam int NUM_MASK = 4;
	localparam int NUM_FIFO = 16;
	localparam int GRP3_FIRST = 12;
	localparam int GRP3_COUNT = 4;
	// Filter control byte layout
	localparam int FC_ON_BIT = 7;
	localparam int FC_MSEL_LSB = 5;
	localparam int FC_FSEL_LSB = 0;
	localparam int FC_BYTE = 8;
	// Identifier / mask layout
	localparam int ID_SID_LSB = 21;
	localparam int ID_EXT_BIT = 19;
	localparam int ID_EID_LSB = 0;
	localparam logic [31:0] ID_WMASK = 32'hFFEB_FFFF;
	// Operating mode field of main control
	localparam int OPMODE_LSB = 21;
	localparam logic [2:0] OPMODE_CONFIG = 3'h4;
	localparam logic [2:0] OPMODE_RESET = 3'h4;
	// Buffer base alignment and depth field
	localparam logic [31:0] BASE_WMASK = 32'hFFFF_FFFC;
	localparam int DEPTH_LSB = 16;
	localparam logic [4:0] FSEL_RESERVED = 5'h10;
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
	// Avalon slave answer state
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} caf_bus_t;
endpackage

// File: src/caf_filter_config.sv
// Acceptance filter configuration, identifier matching and buffer base
// address for a CAN controller, reached over Avalon-MM with waitrequest.
// Assumes filters 0-11 controls come from sibling logic on the same clock.
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module caf_filter_config #(
	parameter int MSG_BYTES = 16
) (
	input wire logic i_clk, // System clock
	input wire logic i_rst, // Async reset, active high
	input wire logic [7:0] i_avs_address, // Byte address
	input wire logic i_avs_read, // Read request
	input wire logic i_avs_write, // Write request
	input wire logic [31:0] i_avs_writedata, // Write data
	input wire logic [3:0] i_avs_byteenable, // Byte lanes
	output logic [31:0] o_avs_readdata, // Read data
	output logic o_avs_waitrequest, // Stall
	input wire logic [11:0] i_low_filter_on, // Enables, filters 0-11
	input wire logic [23:0] i_low_mask_choice, // Mask codes, filters 0-11
	input wire logic [59:0] i_low_fifo_target, // FIFO codes, filters 0-11
	input wire logic i_rx_valid, // Received identifier strobe
	input wire logic i_rx_extended, // Received frame is extended
	input wire logic [10:0] i_rx_sid, // Received standard identifier
	input wire logic [17:0] i_rx_eid, // Received extended portion
	output logic o_match_valid, // Match answer strobe
	output logic o_match_hit, // Some filter accepted
	output logic [3:0] o_match_filter, // Winning filter index
	output logic [4:0] o_match_fifo, // Target FIFO of winner
	output logic [2:0] o_operating_mode_field, // Current mode
	output logic [31:0] o_buffer_base_address // Base of buffers
);
	caf_pkg::caf_bus_t bus_q;
	logic [31:0] rdata_q;
	logic [2:0] opmode_q;
	logic [31:0] grp3_q;
	logic [31:0] base_q;
	logic [31:0] mask_q [caf_pkg::NUM_MASK];
	logic [31:0] ident_q [caf_pkg::NUM_FILT];
	logic [4:0] depth_q [caf_pkg::NUM_FIFO];
	logic [31:0] start_w [caf_pkg::NUM_FIFO];
	logic f_on [caf_pkg::NUM_FILT];
	logic [1:0] f_msel [caf_pkg::NUM_FILT];
	logic [4:0] f_fsel [caf_pkg::NUM_FILT];
	logic commit;
	logic [5:0] widx;
	logic [31:0] bmask;
	logic hit_d;
	logic [3:0] filt_d;
	logic [4:0] fifo_d;

	// Byte enables spread to a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// Stall the first cycle of each request, release on the second
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) && (bus_q == caf_pkg::BUS_IDLE);
	assign commit = i_avs_write && (bus_q == caf_pkg::BUS_ACK);
	assign widx = i_avs_address[7:caf_pkg::WORD_SHIFT];
	assign bmask = lane_mask(i_avs_byteenable);
	assign o_avs_readdata = rdata_q;
	assign o_operating_mode_field = opmode_q;
	assign o_buffer_base_address = base_q;

	// Answer state
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bus_q <= caf_pkg::BUS_IDLE;
		end else if (bus_q == caf_pkg::BUS_ACK) begin
			bus_q <= caf_pkg::BUS_IDLE;
		end else if (i_avs_read | i_avs_write) begin
			bus_q <= caf_pkg::BUS_ACK;
		end
	end

	// Per-filter fields, low filters from ports, group 3 from register
	always_comb begin
		for (int i = 0; i < caf_pkg::GRP3_FIRST; i++) begin
			f_on[i] = i_low_filter_on[i];
			f_msel[i] = i_low_mask_choice[2*i +: 2];
			f_fsel[i] = i_low_fifo_target[5*i +: 5];
		end
		// Split loops keep every select inside its vector
		for (int i = caf_pkg::GRP3_FIRST; i < caf_pkg::NUM_FILT; i++) begin
			f_on[i] = grp3_q[caf_pkg::FC_BYTE*(i-caf_pkg::GRP3_FIRST)
				+ caf_pkg::FC_ON_BIT];
			f_msel[i] = grp3_q[caf_pkg::FC_BYTE*(i-caf_pkg::GRP3_FIRST)
				+ caf_pkg::FC_MSEL_LSB +: 2];
			f_fsel[i] = grp3_q[caf_pkg::FC_BYTE*(i-caf_pkg::GRP3_FIRST)
				+ caf_pkg::FC_FSEL_LSB +: 5];
		end
	end

	// Main control: only the operating mode field is held here
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			opmode_q <= caf_pkg::OPMODE_RESET;
		end else if (commit && i_avs_address == caf_pkg::OFS_MAIN_CTRL
				&& i_avs_byteenable[2]) begin
			opmode_q <= i_avs_writedata[caf_pkg::OPMODE_LSB +: 3];
		end
	end

	// Group 3 control; selectors locked while the filter is on
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			grp3_q <= caf_pkg::RESET_ZERO;
		end else if (commit && i_avs_address == caf_pkg::OFS_FLT_GRP3) begin
			for (int b = 0; b < caf_pkg::GRP3_COUNT; b++) begin
				if (i_avs_byteenable[b]) begin
					grp3_q[caf_pkg::FC_BYTE*b + caf_pkg::FC_ON_BIT] <=
						i_avs_writedata[caf_pkg::FC_BYTE*b + caf_pkg::FC_ON_BIT];
					if (!grp3_q[caf_pkg::FC_BYTE*b + caf_pkg::FC_ON_BIT]) begin
						grp3_q[caf_pkg::FC_BYTE*b +: 7] <=
							i_avs_writedata[caf_pkg::FC_BYTE*b +: 7];
					end
				end
			end
		end
	end

	// Buffer base; writable only in configuration mode, low bits zero
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			base_q <= caf_pkg::RESET_ZERO;
		end else if (commit && i_avs_address == caf_pkg::OFS_BUF_BASE
				&& opmode_q == caf_pkg::OPMODE_CONFIG) begin
			base_q <= ((base_q & ~bmask) | (i_avs_writedata & bmask))
				& caf_pkg::BASE_WMASK;
		end
	end

	// Acceptance masks, same layout as identifiers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int m = 0; m < caf_pkg::NUM_MASK; m++) begin
				mask_q[m] <= caf_pkg::RESET_ZERO;
			end
		end else if (commit) begin
			for (int m = 0; m < caf_pkg::NUM_MASK; m++) begin
				if (widx == 6'((caf_pkg::OFS_MASK0 >> caf_pkg::WORD_SHIFT) + m)) begin
					mask_q[m] <= ((mask_q[m] & ~bmask) | (i_avs_writedata & bmask))
						& caf_pkg::ID_WMASK;
				end
			end
		end
	end

	// Filter identifiers; locked while the filter is on
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int f = 0; f < caf_pkg::NUM_FILT; f++) begin
				ident_q[f] <= caf_pkg::RESET_ZERO;
			end
		end else if (commit) begin
			for (int f = 0; f < caf_pkg::NUM_FILT; f++) begin
				if (widx == 6'((caf_pkg::OFS_FILT_ID0 >> caf_pkg::WORD_SHIFT) + f)
						&& !f_on[f]) begin
					ident_q[f] <= ((ident_q[f] & ~bmask) | (i_avs_writedata & bmask))
						& caf_pkg::ID_WMASK;
				end
			end
		end
	end

	// FIFO depth fields
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int q = 0; q < caf_pkg::NUM_FIFO; q++) begin
				depth_q[q] <= 5'h00;
			end
		end else if (commit && i_avs_byteenable[2]) begin
			for (int q = 0; q < caf_pkg::NUM_FIFO; q++) begin
				if (widx == 6'((caf_pkg::OFS_DEPTH0 >> caf_pkg::WORD_SHIFT) + q)) begin
					depth_q[q] <= i_avs_writedata[caf_pkg::DEPTH_LSB +: 5];
				end
			end
		end
	end

	// Start of each FIFO's buffer, contiguous by index
	always_comb begin
		logic [31:0] acc;
		acc = base_q;
		for (int q = 0; q < caf_pkg::NUM_FIFO; q++) begin
			start_w[q] = acc;
			acc = acc + (32'(depth_q[q]) + 32'h1) * 32'(MSG_BYTES);
		end
	end

	// Read data, captured while the request is stalled
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= caf_pkg::RESET_ZERO;
		end else if (i_avs_read && bus_q == caf_pkg::BUS_IDLE) begin
			if (i_avs_address == caf_pkg::OFS_MAIN_CTRL) begin
				rdata_q <= 32'(opmode_q) << caf_pkg::OPMODE_LSB;
			end else if (i_avs_address == caf_pkg::OFS_FLT_GRP3) begin
				rdata_q <= grp3_q;
			end else if (i_avs_address == caf_pkg::OFS_BUF_BASE) begin
				rdata_q <= base_q;
			end else if (i_avs_address >= caf_pkg::OFS_MASK0
					&& i_avs_address < caf_pkg::OFS_FILT_ID0) begin
				rdata_q <= mask_q[widx[1:0]];
			end else if (i_avs_address >= caf_pkg::OFS_FILT_ID0
					&& i_avs_address < caf_pkg::OFS_DEPTH0) begin
				rdata_q <= ident_q[4'(widx - 6'(caf_pkg::OFS_FILT_ID0 >> caf_pkg::WORD_SHIFT))];
			end else if (i_avs_address >= caf_pkg::OFS_DEPTH0
					&& i_avs_address < caf_pkg::OFS_START0) begin
				rdata_q <= 32'(depth_q[4'(widx - 6'(caf_pkg::OFS_DEPTH0
					>> caf_pkg::WORD_SHIFT))]) << caf_pkg::DEPTH_LSB;
			end else if (i_avs_address >= caf_pkg::OFS_START0
					&& i_avs_address < 8'(caf_pkg::OFS_START0
					+ (caf_pkg::NUM_FIFO << caf_pkg::WORD_SHIFT))) begin
				rdata_q <= start_w[4'(widx - 6'(caf_pkg::OFS_START0 >> caf_pkg::WORD_SHIFT))];
			end else begin
				rdata_q <= caf_pkg::RESET_ZERO; // Unmapped reads zero
			end
		end
	end

	// Priority match, lowest filter index wins
	always_comb begin
		logic [31:0] m;
		logic [31:0] id;
		logic ok;
		m = caf_pkg::RESET_ZERO;
		id = caf_pkg::RESET_ZERO;
		ok = 1'b0;
		hit_d = 1'b0;
		filt_d = 4'h0;
		fifo_d = 5'h00;
		for (int f = caf_pkg::NUM_FILT - 1; f >= 0; f--) begin
			m = mask_q[f_msel[f]];
			id = ident_q[f];
			ok = f_on[f]
				&& f_fsel[f] < caf_pkg::FSEL_RESERVED
				&& id[caf_pkg::ID_EXT_BIT] == i_rx_extended
				&& ((id[caf_pkg::ID_SID_LSB +: 11] ^ i_rx_sid)
					& m[caf_pkg::ID_SID_LSB +: 11]) == 11'h000
				&& (!i_rx_extended || ((id[caf_pkg::ID_EID_LSB +: 18] ^ i_rx_eid)
					& m[caf_pkg::ID_EID_LSB +: 18]) == 18'h00000);
			if (ok) begin
				hit_d = 1'b1;
				filt_d = 4'(f);
				fifo_d = f_fsel[f];
			end
		end
	end

	// Registered match answer
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_match_valid <= 1'b0;
			o_match_hit <= 1'b0;
			o_match_filter <= 4'h0;
			o_match_fifo <= 5'h00;
		end else begin
			o_match_valid <= i_rx_valid;
			if (i_rx_valid) begin
				o_match_hit <= hit_d;
				o_match_filter <= filt_d;
				o_match_fifo <= fifo_d;
			end
		end
	end
endmodule
`default_nettype wire

// File: test/caf_filter_config_monitor.sv
// Port checker for the filter block.
// Assumes one clock; bound from the bench top.
`timescale 1ns/10ps
`default_nettype none
module caf_filter_config_monitor (
	input wire logic i_clk, // Clock
	input wire logic i_rst, // Reset
	input wire logic [7:0] i_avs_address, // Address
	input wire logic i_avs_write, // Write
	input wire logic [31:0] i_avs_writedata, // Data
	input wire logic [3:0] i_avs_byteenable, // Lanes
	input wire logic o_avs_waitrequest, // Stall
	input wire logic i_rx_valid, // Rx strobe
	input wire logic o_match_valid, // Answer
	input wire logic [4:0] o_match_fifo, // Target
	input wire logic [2:0] o_operating_mode_field, // Mode
	input wire logic [31:0] o_buffer_base_address // Base
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	// Full-word base write taken
	sequence s_base_wr;
		i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h08 && i_avs_byteenable == 4'hF;
	endsequence
	sequence s_cfg;
		o_operating_mode_field == caf_pkg::OPMODE_CONFIG;
	endsequence
	property p_take;
		s_base_wr ##0 s_cfg |=> o_buffer_base_address == ($past(i_avs_writedata) & 32'hFFFF_FFFC);
	endproperty
	a_take: assert property (p_take) else $error("base write lost");
	property p_lock;
		s_base_wr ##0 (o_operating_mode_field != 3'h4) |=> $stable(o_buffer_base_address);
	endproperty
	a_lock: assert property (p_lock) else $error("base changed out of config");
	property p_quiet;
		!i_avs_write |=> $stable(o_buffer_base_address) && $stable(o_operating_mode_field);
	endproperty
	a_quiet: assert property (p_quiet) else $error("register moved alone");
	property p_wait;
		$rose(i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("write answer timing");
	property p_align;
		o_buffer_base_address[1:0] == 2'h0;
	endproperty
	a_align: assert property (p_align) else $error("base not aligned");
	property p_lat;
		i_rx_valid |=> o_match_valid;
	endproperty
	a_lat: assert property (p_lat) else $error("no match answer");
	property p_idle;
		!i_rx_valid |=> !o_match_valid;
	endproperty
	a_idle: assert property (p_idle) else $error("stray match answer");
	property p_fifo;
		o_match_valid |-> !o_match_fifo[4];
	endproperty
	a_fifo: assert property (p_fifo) else $error("reserved fifo code");
endmodule
`default_nettype wire

// File: test/caf_rx_node.sv
// Model of a CAN node handing received identifiers in.
// Assumes the bench calls send; lines scramble between frames.
`timescale 1ns/10ps
`default_nettype none
module caf_rx_node (
	input wire logic i_clk, // Clock
	output logic o_valid, // Strobe
	output logic o_ext, // Extended frame
	output logic [10:0] o_sid, // Standard id
	output logic [17:0] o_eid // Extended id
);
	initial {o_valid, o_ext, o_sid, o_eid} = '0;
	// One strobe, then inverted lines
	task automatic send(input logic e, input logic [10:0] s, input logic [17:0] x);
		@(posedge i_clk);
		{o_valid, o_ext, o_sid, o_eid} <= {1'b1, e, s, x};
		@(posedge i_clk);
		{o_valid, o_ext, o_sid, o_eid} <= {1'b0, ~e, ~s, ~x};
		#1;
	endtask
endmodule
`default_nettype wire

// File: test/tb_caf_filter_config.sv
// Bench: Avalon tasks and filter scenarios.
// Assumes the package, design, rx node and monitor.
`timescale 1ns/10ps
`default_nettype none
module tb_caf_filter_config;
	localparam logic [7:0] ID13 = 8'h54;
	logic i_clk = 1'b0, i_rst = 1'b1, rd = 1'b0, wr = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] be = 4'hF;
	logic [31:0] wd = 32'h0, rdat, base, got;
	logic wq, mv, mh, rv, re;
	logic [3:0] mf;
	logic [4:0] mq;
	logic [2:0] mode;
	logic [10:0] rs;
	logic [17:0] rx_e;
	int n_errors = 0, compares = 0, cyc = 0;
	always #5 i_clk = ~i_clk;
	caf_filter_config #(.MSG_BYTES(16)) i_caf_filter_config (.i_clk(i_clk), .i_rst(i_rst),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wq),
		.i_low_filter_on(12'h0), .i_low_mask_choice(24'h0), .i_low_fifo_target(60'h0),
		.i_rx_valid(rv), .i_rx_extended(re), .i_rx_sid(rs), .i_rx_eid(rx_e),
		.o_match_valid(mv), .o_match_hit(mh), .o_match_filter(mf), .o_match_fifo(mq),
		.o_operating_mode_field(mode), .o_buffer_base_address(base));
	caf_rx_node i_caf_rx_node (.i_clk(i_clk), .o_valid(rv), .o_ext(re), .o_sid(rs), .o_eid(rx_e));
	task automatic chk(input logic [31:0] s, input logic [31:0] w);
		compares++;
		if (s !== w) begin
			n_errors++;
			$display("BAD t=%0t seen=%h want=%h", $time, s, w);
		end
	endtask
	// One bus cycle, held until waitrequest is low
	task automatic acc(input logic r, input logic [7:0] a, input logic [31:0] d);
		logic w;
		@(posedge i_clk);
		{adr, wd, rd, wr} <= {a, d, r, ~r};
		do begin
			@(posedge i_clk);
			w = wq;
			got = rdat;
		end while (w !== 1'b0);
		{rd, wr} <= 2'b00;
	endtask
	// Identifier through the node, answer of filter 13
	task automatic rx(input logic e, input logic [10:0] s, input logic [17:0] x, input logic h,
		input logic [4:0] q);
		i_caf_rx_node.send(e, s, x);
		chk({30'h0, mv, mh}, {30'h0, 1'b1, h});
		if (h) chk({23'h0, mf, mq}, {23'h0, 4'hD, q});
	endtask
	task automatic print_verdict();
		$display("n_errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		acc(1'b1, 8'h00, 32'h0);
		chk(got, 32'h0080_0000);
		acc(1'b1, 8'hFC, 32'h0);
		chk(got, 32'h0);
		// Base, depth and buffer starts
		acc(1'b0, 8'h08, 32'h1234_5677);
		acc(1'b0, 8'h60, 32'h0003_0000);
		for (int q = 0; q < 3; q++) begin
			acc(1'b1, 8'hA0 + 8'(4 * q), 32'h0);
			chk(got, 32'h1234_5674 + 32'(q * 16 + (q > 0 ? 48 : 0)));
		end
		acc(1'b0, 8'h00, 32'h0);
		acc(1'b0, 8'h08, 32'hFFFF_0000);
		chk({29'h0, mode}, 32'h0);
		chk(base, 32'h1234_5674);
		acc(1'b0, 8'h00, 32'h0080_0000);
		acc(1'b0, ID13, 32'hFFFF_FFFF);
		acc(1'b1, ID13, 32'h0);
		chk(got, 32'hFFEB_FFFF);
		acc(1'b0, ID13, 32'h0);
		// Mask m compares standard bit m only
		for (int m = 0; m < 4; m++) acc(1'b0, 8'h10 + 8'(4 * m), 32'h0020_0000 << m);
		for (int m = 0; m < 4; m++) begin
			acc(1'b0, 8'h04, 32'h0);
			acc(1'b0, 8'h04, {16'h0, 1'b1, 2'(m), 5'(m + 4), 8'h00});
			rx(1'b0, 11'(1 << m), 18'h0, 1'b0, 5'h0);
			rx(1'b0, 11'(1 << ((m + 1) % 4)), 18'h0, 1'b1, 5'(m + 4));
		end
		// Enabled filter keeps selectors and identifier
		acc(1'b0, 8'h04, 32'h0000_8200);
		acc(1'b1, 8'h04, 32'h0);
		chk(got, 32'h0000_E700);
		acc(1'b0, ID13, 32'h0020_0000);
		acc(1'b1, ID13, 32'h0);
		chk(got, 32'h0);
		rx(1'b1, 11'h0, 18'h0, 1'b0, 5'h0);
		acc(1'b0, 8'h04, 32'h0000_6700);
		rx(1'b0, 11'h0, 18'h0, 1'b0, 5'h0);
		// Extended-only filter, full mask
		acc(1'b0, 8'h1C, 32'hFFEB_FFFF);
		acc(1'b1, 8'h1C, 32'h0);
		chk(got, 32'hFFEB_FFFF);
		acc(1'b0, ID13, 32'h00AA_A5A5);
		acc(1'b0, 8'h04, 32'h0000_EF00);
		rx(1'b1, 11'h005, 18'h2A5A5, 1'b1, 5'h0F);
		rx(1'b1, 11'h005, 18'h2A5A4, 1'b0, 5'h0);
		rx(1'b1, 11'h004, 18'h2A5A5, 1'b0, 5'h0);
		// Reserved FIFO code never routes a message
		acc(1'b0, 8'h04, 32'h0000_0000);
		acc(1'b0, 8'h04, 32'h0000_F000);
		rx(1'b1, 11'h005, 18'h2A5A5, 1'b0, 5'h0);
		// Reset in mid-run clears base and group 3
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		acc(1'b1, 8'h08, 32'h0);
		chk(got, 32'h0);
		acc(1'b1, 8'h04, 32'h0);
		chk(got, 32'h0);
		print_verdict();
	end
endmodule
bind caf_filter_config caf_filter_config_monitor i_caf_filter_config_monitor (.i_clk(i_clk),
	.i_rst(i_rst), .i_avs_address(i_avs_address), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
	.o_avs_waitrequest(o_avs_waitrequest), .i_rx_valid(i_rx_valid), .o_match_valid(o_match_valid),
	.o_match_fifo(o_match_fifo), .o_operating_mode_field(o_operating_mode_field),
	.o_buffer_base_address(o_buffer_base_address));
`default_nettype wire
